// File: logic/pmsc_pkg.sv
// Purpose: shared constants and types for the pluggable module sideband control
// Assumes: 40 MHz core clock
// Notes: durations are parameters in ns; cycle counts derive from them
package pmsc_pkg;
  localparam int unsigned CLK_PERIOD_NS       = 25;
  // no printed figures exist for these; plain defaults
  localparam int unsigned RESET_PULSE_MIN_NS  = 10000;
  localparam int unsigned RESET_INIT_NS       = 2000000;
  // least time rounds up, at least one cycle
  localparam int unsigned RESET_PULSE_CYCLES  =
    (RESET_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RESET_INIT_CYCLES   =
    (RESET_INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W               = 32;
  localparam logic        SYNC_RESET_VAL      = 1'b1;
  localparam logic        SETTINGS_DEFAULT    = 1'b0;

  typedef enum logic [1:0] {
    PMSC_ST_RUN   = 2'b00,
    PMSC_ST_PULSE = 2'b01,
    PMSC_ST_INIT  = 2'b11,
    PMSC_ST_POST  = 2'b10
  } pmsc_state_t;
endpackage

// File: logic/pmsc_sync_if.sv
// Purpose: carries synchronised pin levels from the synchroniser to the control core
// Assumes: one clock domain
// Notes: all signals are levels
`timescale 1ns/1ps
interface pmsc_sync_if;
  logic select_n;
  logic reset_n;
  logic low_power;
  modport src (output select_n, output reset_n, output low_power);
  modport dst (input select_n, input reset_n, input low_power);
endinterface // pmsc_sync_if

// File: logic/pmsc_sync.sv
// Purpose: two-flop synchronisers for the host-driven pins
// Assumes: pins are asynchronous to clk
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
module pmsc_sync (
  // clock and reset
  input  wire logic   clk,
  input  wire logic   rst,
  // raw pins
  input  wire logic   module_select_pin,
  input  wire logic   module_reset_n,
  input  wire logic   low_power_request,
  // synchronised levels
  pmsc_sync_if.src    sync
);
  logic [2:0] stage1_reg;
  logic [2:0] stage2_reg;

  // resets to idle: deselected, not in reset, full power
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1_reg <= {pmsc_pkg::SYNC_RESET_VAL, pmsc_pkg::SYNC_RESET_VAL, 1'b0};
      stage2_reg <= {pmsc_pkg::SYNC_RESET_VAL, pmsc_pkg::SYNC_RESET_VAL, 1'b0};
    end else begin
      stage1_reg <= {module_select_pin, module_reset_n, low_power_request};
      stage2_reg <= stage1_reg;
    end
  end

  assign sync.select_n  = stage2_reg[2];
  assign sync.reset_n   = stage2_reg[1];
  assign sync.low_power = stage2_reg[0];
endmodule // pmsc_sync

// File: logic/pmsc_top.sv
// Purpose: sideband control of a pluggable optical module (select, reset, low power,
//          presence, interrupt)
// Assumes: host pins asynchronous to the 40 MHz clk; rst is power-on reset
// Notes on behaviour
// R1: select low lets the module accept and answer management bus commands.
// R2: select high makes the module ignore all management bus traffic.
// R3: select input pulled up internally; undriven means deselected.
// R4: reset low longer than minimum pulse resets all user settings to default.
// R5: initialisation interval starts at the rising edge ending the reset pulse.
// R6: host ignores status bits until the module reports reset complete.
// R7: reset complete is shown by interrupt low with data-pending flag cleared.
// R8: after power-up the module posts reset-complete interrupt unprompted.
// R9: low-power request high puts the module in low-power mode.
// R10: presence output tied low inside the module.
// R11: interrupt driven low for faults or critical status.
// R12: host reads the module over the bus to find the interrupt cause.
// R13: interrupt output is open-collector: pull low or release.
// R14: minimum reset pulse and initialisation durations are parameters.
`timescale 1ns/1ps
module pmsc_top #(
  parameter int unsigned RESET_PULSE_CYCLES = pmsc_pkg::RESET_PULSE_CYCLES, // [R14]
  parameter int unsigned RESET_INIT_CYCLES  = pmsc_pkg::RESET_INIT_CYCLES   // [R14]
) (
  // clock and reset
  input  wire logic  clk,
  input  wire logic  rst,
  // host pins
  input  wire logic  module_select_pin,
  input  wire logic  module_select_pe,
  input  wire logic  module_reset_n,
  input  wire logic  low_power_request,
  output logic       module_present_n,
  output logic       module_present_oe,
  output logic       interrupt_n,
  output logic       interrupt_oe,
  // towards the management bus engine and module core
  output logic       bus_enable,
  output logic       settings_reset,
  output logic       low_power_mode,
  output logic       data_not_ready,
  // status from the module core
  input  wire logic  fault_event,
  input  wire logic  interrupt_clear
);
  pmsc_sync_if sync ();
  pmsc_pkg::pmsc_state_t state_reg;
  pmsc_pkg::pmsc_state_t state_next;
  logic [pmsc_pkg::CNT_W-1:0] count_reg;
  logic [pmsc_pkg::CNT_W-1:0] count_next;
  logic select_pin_eff;
  logic fault_reg;
  logic complete_reg;
  logic fault_sync1_reg;
  logic fault_sync2_reg;
  logic clear_sync1_reg;
  logic clear_sync2_reg;

  // an undriven pin reads high, as the internal pull-up would make it
  assign select_pin_eff = module_select_pe ? module_select_pin : 1'b1; // [R3]

  pmsc_sync u_sync (
    .clk               (clk),
    .rst               (rst),
    .module_select_pin (select_pin_eff),
    .module_reset_n    (module_reset_n),
    .low_power_request (low_power_request),
    .sync              (sync.src)
  );

  // status inputs may come from another block; synchronise to be safe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fault_sync1_reg <= 1'b0;
      fault_sync2_reg <= 1'b0;
      clear_sync1_reg <= 1'b0;
      clear_sync2_reg <= 1'b0;
    end else begin
      fault_sync1_reg <= fault_event;
      fault_sync2_reg <= fault_sync1_reg;
      clear_sync1_reg <= interrupt_clear;
      clear_sync2_reg <= clear_sync1_reg;
    end
  end

  // reset sequencer: power-up enters init directly so completion is posted unasked
  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    case (state_reg)
      pmsc_pkg::PMSC_ST_RUN: begin
        if (!sync.reset_n) begin
          state_next = pmsc_pkg::PMSC_ST_PULSE;
          count_next = '0;
        end
      end
      pmsc_pkg::PMSC_ST_PULSE: begin
        if (sync.reset_n) begin
          // short glitches are not a reset
          if (count_reg >= RESET_PULSE_CYCLES[pmsc_pkg::CNT_W-1:0]) begin // [R4]
            state_next = pmsc_pkg::PMSC_ST_INIT; // [R5]
          end else begin
            state_next = pmsc_pkg::PMSC_ST_RUN;
          end
          count_next = '0;
        end else if (count_reg < RESET_PULSE_CYCLES[pmsc_pkg::CNT_W-1:0]) begin
          count_next = count_reg + 1'b1;
        end
      end
      pmsc_pkg::PMSC_ST_INIT: begin
        if (!sync.reset_n) begin
          state_next = pmsc_pkg::PMSC_ST_PULSE;
          count_next = '0;
        end else if (count_reg >= RESET_INIT_CYCLES[pmsc_pkg::CNT_W-1:0] - 1'b1) begin
          state_next = pmsc_pkg::PMSC_ST_POST;
          count_next = '0;
        end else begin
          count_next = count_reg + 1'b1;
        end
      end
      pmsc_pkg::PMSC_ST_POST: begin
        state_next = pmsc_pkg::PMSC_ST_RUN;
      end
      default: begin
        state_next = pmsc_pkg::PMSC_ST_RUN;
        count_next = '0;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= pmsc_pkg::PMSC_ST_INIT; // [R8]
      count_reg <= '0;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
    end
  end

  // settings held in default while a qualified reset pulse is seen or init runs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      settings_reset <= 1'b1;
    end else begin
      settings_reset <= (state_next == pmsc_pkg::PMSC_ST_INIT) ||
                        (state_next == pmsc_pkg::PMSC_ST_PULSE &&
                         count_next >= RESET_PULSE_CYCLES[pmsc_pkg::CNT_W-1:0]); // [R4]
    end
  end

  // status is meaningless to the host until init finishes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_not_ready <= 1'b1;
    end else if (state_next == pmsc_pkg::PMSC_ST_INIT) begin
      data_not_ready <= 1'b1; // [R6]
    end else if (state_reg == pmsc_pkg::PMSC_ST_POST) begin
      data_not_ready <= 1'b0; // [R7]
    end
  end

  // interrupt sources are sticky; a new event beats a clear in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      complete_reg <= 1'b0;
      fault_reg    <= 1'b0;
    end else begin
      if (state_reg == pmsc_pkg::PMSC_ST_POST) begin
        complete_reg <= 1'b1; // [R7] [R8]
      end else if (clear_sync2_reg || state_next == pmsc_pkg::PMSC_ST_INIT) begin
        complete_reg <= 1'b0;
      end
      if (fault_sync2_reg && state_next == pmsc_pkg::PMSC_ST_RUN) begin
        fault_reg <= 1'b1; // [R11]
      end else if (clear_sync2_reg || state_next == pmsc_pkg::PMSC_ST_INIT) begin
        fault_reg <= 1'b0;
      end
    end
  end

  // open-collector: data is always 0, only the enable moves
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      interrupt_n  <= 1'b0;
      interrupt_oe <= 1'b0;
    end else begin
      interrupt_n  <= 1'b0; // [R13]
      interrupt_oe <= (state_reg == pmsc_pkg::PMSC_ST_POST) || complete_reg ||
                      (fault_sync2_reg && state_next == pmsc_pkg::PMSC_ST_RUN) ||
                      fault_reg; // [R11] [R13]
    end
  end

  // presence is a hard ground, driven from reset onward
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      module_present_n  <= 1'b0;
      module_present_oe <= 1'b1;
    end else begin
      module_present_n  <= 1'b0; // [R10]
      module_present_oe <= 1'b1; // [R10]
    end
  end

  // bus engine answers only when selected; during init it still may answer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus_enable <= 1'b0;
    end else begin
      bus_enable <= !sync.select_n; // [R1] [R2]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      low_power_mode <= 1'b0;
    end else begin
      low_power_mode <= sync.low_power; // [R9]
    end
  end
endmodule // pmsc_top

// File: sim/pmsc_monitor.sv
// Purpose: port assertions for pmsc_top
// Assumes: counts shortened in sim
// Notes: wide windows absorb sync lag
`timescale 1ns/1ps
module pmsc_monitor #(
  parameter int unsigned RESET_PULSE_CYCLES = 4,
  parameter int unsigned RESET_INIT_CYCLES  = 20
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pins
  input wire logic module_select_pin,
  input wire logic module_select_pe,
  input wire logic module_reset_n,
  input wire logic low_power_request,
  input wire logic module_present_n,
  input wire logic module_present_oe,
  input wire logic interrupt_n,
  input wire logic interrupt_oe,
  // core side
  input wire logic bus_enable,
  input wire logic settings_reset,
  input wire logic low_power_mode,
  input wire logic data_not_ready,
  // core status
  input wire logic fault_event
);
  localparam int P  = RESET_PULSE_CYCLES;
  localparam int LO = RESET_INIT_CYCLES - 10;
  localparam int HI = RESET_INIT_CYCLES + 12;
  logic [7:0] up_cnt;
  logic [7:0] low_cnt;
  wire        sel_eff = module_select_pe ? module_select_pin : 1'b1;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      up_cnt  <= 8'h00;
      low_cnt <= 8'h00;
    end else begin
      up_cnt  <= (up_cnt == 8'hff) ? up_cnt : up_cnt + 8'h01;
      low_cnt <= module_reset_n ? 8'h00 : low_cnt + 8'h01;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence busy_s; (data_not_ready && !interrupt_oe) [*8]; endsequence
  sequence done_s; !data_not_ready && interrupt_oe; endsequence
  // reset pin high and status valid rules out every state but run
  sequence fault_held_s; (fault_event && module_reset_n && !data_not_ready) [*6]; endsequence
  a_select_gates_bus: assert property (up_cnt > 8'h04 |->
    bus_enable == !$past(sel_eff, 3)) else $error("select");
  a_low_power_follows: assert property (up_cnt > 8'h04 |->
    low_power_mode == $past(low_power_request, 3)) else $error("low power");
  a_presence_tied: assert property (module_present_oe && !module_present_n)
    else $error("presence");
  a_intr_open_drain: assert property (!interrupt_n)
    else $error("drive high");
  a_power_up_post: assert property (up_cnt == 8'h01 |-> busy_s ##[LO:HI] done_s)
    else $error("power-up");
  a_long_reset_holds: assert property (low_cnt == P + 5 |-> settings_reset)
    else $error("no reset");
  a_short_pulse_ignored: assert property ($rose(module_reset_n) && low_cnt < P - 1
    && !data_not_ready |-> !(data_not_ready || settings_reset) [*8]) else $error("short");
  a_init_after_pulse: assert property ($rose(module_reset_n) && low_cnt > P + 1
    |-> ##4 busy_s ##[LO:HI] done_s) else $error("init");
  a_fault_raises_intr: assert property (fault_held_s |-> interrupt_oe)
    else $error("fault");
endmodule // pmsc_monitor
bind pmsc_top pmsc_monitor #(.RESET_PULSE_CYCLES(RESET_PULSE_CYCLES),
  .RESET_INIT_CYCLES(RESET_INIT_CYCLES)) u_pmsc_monitor (.clk, .rst, .module_select_pin,
  .module_select_pe, .module_reset_n, .low_power_request, .module_present_n,
  .module_present_oe, .interrupt_n, .interrupt_oe, .bus_enable, .settings_reset,
  .low_power_mode, .data_not_ready, .fault_event);

// File: sim/pmsc_host_model.sv
// Purpose: host board model
// Assumes: host pull-up on the interrupt line
// Notes: undriven select wanders
`timescale 1ns/1ps
module pmsc_host_model (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // bench control
  input  wire logic sel_drive,
  input  wire logic sel_val,
  input  wire logic svc_en,
  // module side
  input  wire logic int_n,
  input  wire logic int_oe,
  input  wire logic dnr,
  output logic      sel_pin,
  output logic      int_wire,
  output logic      read_done
);
  logic       wander;
  logic [1:0] rd_q;
  assign sel_pin   = sel_drive ? sel_val : wander;
  assign int_wire  = int_oe ? int_n : 1'b1;
  assign read_done = rd_q[1];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wander <= 1'b0;
      rd_q   <= 2'h0;
    end else begin
      wander <= !wander;
      // status trusted only once ready
      rd_q   <= {rd_q[0], svc_en && !int_wire && !dnr};
    end
  end
endmodule // pmsc_host_model

// File: sim/tb.sv
// Purpose: self-checking bench for pmsc_top
// Assumes: pulse 4, init 20 cycles
// Notes: obs bits prs,int,bus,lp,oe,dnr,sr
`timescale 1ns/1ps
module tb;
  logic       clk = 1'b0, rst = 1'b1, drv = 1'b1, sv = 1'b1, rn = 1'b1, lp = 1'b0;
  logic       flt = 1'b0, svc = 1'b0, sp, iw, rd, pn, po, inn, ioe, be, sr, lpm, dnr;
  logic [7:0] seed = 8'h62;
  logic [6:0] eq[$], mq[$], e, m;
  int         error_cnt = 0, n_compared = 0, cycles = 0;
  wire  [6:0] obs = {po ? pn : 1'b1, iw, be, lpm, ioe, dnr, sr};
  always #12.5 clk = ~clk;
  pmsc_top #(.RESET_PULSE_CYCLES(4), .RESET_INIT_CYCLES(20)) u_pmsc_top (.clk(clk), .rst(rst),
    .module_select_pin(sp), .module_select_pe(drv), .module_reset_n(rn),
    .low_power_request(lp), .module_present_n(pn), .module_present_oe(po), .interrupt_n(inn),
    .interrupt_oe(ioe), .bus_enable(be), .settings_reset(sr), .low_power_mode(lpm),
    .data_not_ready(dnr), .fault_event(flt), .interrupt_clear(rd));
  pmsc_host_model u_pmsc_host_model (.clk(clk), .rst(rst), .sel_drive(drv), .sel_val(sv),
    .svc_en(svc), .int_n(inn), .int_oe(ioe), .dnr(dnr), .sel_pin(sp), .int_wire(iw),
    .read_done(rd));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic note(input logic [6:0] ev, input logic [6:0] mv);
    eq.push_back(ev);
    mq.push_back(mv);
  endtask
  task automatic wait_int;
    for (int i = 0; i < 100 && iw !== 1'b0; i++) @(negedge clk);
    // an interrupt that never comes is a mismatch
    if (iw !== 1'b0) error_cnt++;
    cyc(1);
  endtask
  task automatic wrap_up;
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(negedge clk) begin
    while (eq.size() > 0) begin
      e = eq.pop_front();
      m = mq.pop_front();
      n_compared++;
      if ((obs & m) !== (e & m)) begin
        error_cnt++;
        $display("mismatch at %0t exp %h got %h", $time, e & m, obs & m);
      end
    end
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      wrap_up();
    end
  end
  initial begin
    cyc(6);
    rst <= 1'b0;
    wait_int();
    note(7'h04, 7'h7f);
    svc <= 1'b1;
    cyc(8);
    note(7'h20, 7'h7f);
    // random select drive, level and low-power request
    for (int i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      drv <= seed[0];
      sv <= seed[1];
      lp <= seed[2];
      cyc(5);
      note({2'b01, ~(seed[0] ? seed[1] : 1'b1), seed[2], 3'b000}, 7'h7f);
    end
    drv <= 1'b1;
    sv <= 1'b0;
    lp <= 1'b0;
    cyc(5);
    rn <= 1'b0;
    cyc(2);
    rn <= 1'b1;
    cyc(10);
    note(7'h30, 7'h7f);
    rn <= 1'b0;
    cyc(12);
    note(7'h31, 7'h7d);
    rn <= 1'b1;
    cyc(5);
    note(7'h32, 7'h7e);
    wait_int();
    note(7'h14, 7'h7f);
    cyc(10);
    svc <= 1'b0;
    flt <= 1'b1;
    cyc(6);
    note(7'h14, 7'h7f);
    flt <= 1'b0;
    svc <= 1'b1;
    cyc(10);
    note(7'h30, 7'h7f);
    // a second qualified pulse during init restarts the sequence
    rn <= 1'b0;
    cyc(12);
    rn <= 1'b1;
    cyc(5);
    rn <= 1'b0;
    cyc(12);
    note(7'h31, 7'h7d);
    rn <= 1'b1;
    cyc(5);
    note(7'h33, 7'h7f);
    wait_int();
    note(7'h14, 7'h7f);
    cyc(10);
    note(7'h30, 7'h7f);
    cyc(2);
    wrap_up();
  end
endmodule // tb
